// [dv/vcc_tb.sv]
`include "vcc_regs.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import vcc_pkg::*;

   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic vcoCmpIn = 1'b0;
   logic calClk;
   logic calBusy;
   logic calDone;
   logic [7:0] vcoBand;
   int miscompares = 0;
   int compares = 0;
   logic [31:0] d;
   logic [1:0] r;
   int n;
   int per;
   int prevMax;

   vcc_top #(.BAND_W(8)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .vcoCmpIn(vcoCmpIn), .calClk(calClk), .calBusy(calBusy), .calDone(calDone), .vcoBand(vcoBand));

   // 40 MHz reference, running from time zero so it is present before any run
   always #12.5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////////
   // reporting
   task automatic test_done();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask : chk

   task automatic hang(input string m);
      miscompares++;
      $display("wrong value at %0t: %s never answered", $time, m);
      test_done();
   endtask : hang

   ////////////////////////////////////////////////////////////////////////////
   // bus master: payload held until its ready edge, answer taken at its valid edge
   task automatic wr(input logic [7:0] a, input logic [31:0] dw, input logic [1:0] er);
      int i;
      logic awTaken;
      logic wTaken;
      i = 0;
      awTaken = 1'b0;
      wTaken = 1'b0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= dw;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // each channel is released at its own ready edge, in whatever order they come
      do begin
         @(posedge core_clk);
         i++;
         if (awready === 1'b1 && !awTaken) begin
            awTaken = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !wTaken) begin
            wTaken = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(awTaken && wTaken) && i < 100);
      while (bvalid !== 1'b1 && i < 100) begin
         @(posedge core_clk);
         i++;
      end
      if (i >= 100) hang("write");
      chk(bresp, er, "write response");
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rr);
      int i;
      i = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         i++;
      end while (arready !== 1'b1 && i < 100);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && i < 100) begin
         @(posedge core_clk);
         i++;
      end
      if (i >= 100) hang("read");
      dr = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask : rd

   // one calibration: busy length and calibration clock period measured in cycles
   task automatic cal(input logic [1:0] code, output int nb, output int pr);
      int first;
      logic prev;
      wr(`VCC_OFF_STAGE, {29'h0, code, 1'b0}, `VCC_RESP_OKAY);
      wr(`VCC_OFF_UPDATE, 32'h1, `VCC_RESP_OKAY);
      wr(`VCC_OFF_STAGE, {29'h0, code, 1'b1}, `VCC_RESP_OKAY);
      wr(`VCC_OFF_UPDATE, 32'h1, `VCC_RESP_OKAY);
      nb = 0;
      pr = 0;
      first = -1;
      prev = 1'b0;
      // nothing else is written while the run lasts, staging and update included
      #1;
      while (calBusy === 1'b1 && nb < 1000) begin
         @(posedge core_clk);
         #1;
         nb++;
         if (calClk === 1'b1 && prev === 1'b0) begin
            if (first < 0) first = nb;
            else if (pr == 0) pr = nb - first;
         end
         prev = calClk;
      end
      if (nb >= 1000) hang("calibration");
   endtask : cal

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      // reset values: divider code 3, trigger clear, band at mid
      rd(`VCC_OFF_STAGE, d, r);
      chk(d, 32'h6, "stage after reset");
      rd(`VCC_OFF_STATUS, d, r);
      chk(d, 32'h6, "status after reset");
      rd(`VCC_OFF_BAND, d, r);
      chk(d, 32'h80, "band after reset");
      chk(r, `VCC_RESP_OKAY, "mapped read response");
      $display("test reset done");
      // staged values stay inactive until an update with bit 0 set
      wr(`VCC_OFF_STAGE, 32'h1, `VCC_RESP_OKAY);
      rd(`VCC_OFF_STATUS, d, r);
      chk(d, 32'h6, "status before update");
      wr(`VCC_OFF_UPDATE, 32'h0, `VCC_RESP_OKAY);
      rd(`VCC_OFF_STATUS, d, r);
      chk(d, 32'h6, "status after empty update");
      chk(calBusy, 1'b0, "no run without update");
      wr(`VCC_OFF_STAGE, 32'h0, `VCC_RESP_OKAY);
      wr(`VCC_OFF_UPDATE, 32'h1, `VCC_RESP_OKAY);
      rd(`VCC_OFF_STATUS, d, r);
      chk(d, 32'h0, "status after update");
      $display("test staging done");
      // comparator held high keeps every trial bit
      vcoCmpIn <= 1'b1;
      cal(2'h0, n, per);
      chk(n, 8 * 2 + 1, "busy cycles code 0");
      rd(`VCC_OFF_BAND, d, r);
      chk(d, 32'hFF, "band all kept");
      chk(vcoBand, 8'hFF, "band pin all kept");
      chk(calDone, 1'b1, "done after run");
      // a trigger that stays 1 must not restart
      wr(`VCC_OFF_UPDATE, 32'h1, `VCC_RESP_OKAY);
      #1;
      chk(calBusy, 1'b0, "no restart on steady trigger");
      chk(calDone, 1'b1, "done kept on steady trigger");
      $display("test trigger edge done");
      // clearing the active trigger throws the result away
      wr(`VCC_OFF_STAGE, 32'h0, `VCC_RESP_OKAY);
      wr(`VCC_OFF_UPDATE, 32'h1, `VCC_RESP_OKAY);
      rd(`VCC_OFF_BAND, d, r);
      chk(d, 32'h80, "band discarded");
      chk(vcoBand, 8'h80, "band pin discarded");
      chk(calDone, 1'b0, "done dropped");
      $display("test discard done");
      // every divider code: run length and calibration clock period scale with the ratio
      vcoCmpIn <= 1'b0;
      prevMax = 0;
      for (int c = 0; c < 4; c++) begin
         // phase detector taken as below 12.5 MHz, so every code is a legal pick
         cal(c[1:0], n, per);
         chk(n, 8 * (2 << c) + 1, "busy cycles per code");
         chk(per, 2 << c, "calibration clock period");
         rd(`VCC_OFF_BAND, d, r);
         chk(d, 32'h0, "band all dropped");
         chk(n > prevMax, 1'b1, "slower ratio runs longer");
         prevMax = n;
      end
      $display("test dividers done");
      // unmapped and read-only places
      rd(8'h10, d, r);
      chk(r, `VCC_RESP_SLVERR, "unmapped read response");
      chk(d, 32'h0, "unmapped read data");
      wr(8'h10, 32'h1, `VCC_RESP_SLVERR);
      // only staging and update take writes; status refuses them
      wr(`VCC_OFF_STATUS, 32'h1F, `VCC_RESP_SLVERR);
      rd(`VCC_OFF_STATUS, d, r);
      // last run left done set, divider code 3 and trigger 1 active
      chk(d, 32'h17, "status is read only");
      $display("test map done");
      test_done();
   end

endmodule : tb

// [rtl/vcc_cal_div.sv]
module vcc_cal_div
   import vcc_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic restart,
   input wire logic [1:0] divSel,
   output logic divTick,
   output logic calClk
);

   logic [4:0] cnt;
   logic [4:0] ratio;
   logic lastCnt;
   logic halfCnt;

   // terminal counts for the selected ratio
   assign ratio = vcc_ratio(divSel);
   assign lastCnt = (cnt == ratio - 5'h01);
   assign halfCnt = (cnt == (ratio >> 1) - 5'h01);

   ////////////////////////////////////////////////////////////////////////////////
   // restart realigns the phase so every calibration starts on a full period
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= '0;
         divTick <= 1'h0;
         calClk <= 1'h0;
      end else if (restart) begin
         cnt <= '0;
         divTick <= 1'h0;
         calClk <= 1'h0;
      end else begin
         cnt <= lastCnt ? 5'h00 : cnt + 5'h01;
         divTick <= lastCnt;
         calClk <= (lastCnt || halfCnt) ? ~calClk : calClk;
      end
   end

endmodule : vcc_cal_div

// [rtl/vcc_pkg.sv]
package vcc_pkg;

   // one copy of the calibration settings, staging or active
   typedef struct packed {
      logic [1:0] div;
      logic trig;
   } vcc_cfg_s;

   typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} vcc_state_e;

   // divide ratio for a divider code: 2, 4, 8 or 16
   function automatic logic [4:0] vcc_ratio(input logic [1:0] sel);
      vcc_ratio = 5'h02 << sel;
   endfunction : vcc_ratio

endpackage : vcc_pkg

// [rtl/vcc_regs.svh]
`ifndef VCC_REGS_SVH
`define VCC_REGS_SVH

// register byte offsets on the control bus
`define VCC_AW 8
`define VCC_OFF_STAGE 8'h00
`define VCC_OFF_UPDATE 8'h04
`define VCC_OFF_STATUS 8'h08
`define VCC_OFF_BAND 8'h0C

// field positions of the staging, update and status words
`define VCC_BIT_TRIG 0
`define VCC_DIV_LSB 1
`define VCC_DIV_MSB 2
`define VCC_BIT_UPDATE 0
`define VCC_BIT_BUSY 3
`define VCC_BIT_DONE 4
`define VCC_STATUS_PAD 27

// reset values
`define VCC_DIV_RST 2'h3
`define VCC_TRIG_RST 1'h0

// bus answers
`define VCC_RESP_OKAY 2'h0
`define VCC_RESP_SLVERR 2'h2

`endif

// [rtl/vcc_top.sv]
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`include "vcc_regs.svh"

module vcc_top
   import vcc_pkg::*;
#(
   parameter int BAND_W = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [`VCC_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`VCC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic vcoCmpIn,
   output logic calClk,
   output logic calBusy,
   output logic calDone,
   output logic [BAND_W-1:0] vcoBand
);

   localparam logic [BAND_W-1:0] BAND_MID = {1'b1, {(BAND_W-1){1'b0}}};

   if (BAND_W < 2 || BAND_W > 16) begin : g_chk
      $error("BAND_W must lie between 2 and 16");
   end

   function automatic logic regHit(input logic [`VCC_AW-1:0] a, input logic [`VCC_AW-1:0] off);
      regHit = (a[`VCC_AW-1:2] == off[`VCC_AW-1:2]);
   endfunction : regHit

   vcc_cfg_s stageCfg;
   vcc_cfg_s activeCfg;
   vcc_state_e state;
   logic trigPrev;
   logic startCal;
   logic divTick;
   logic cmpMeta;
   logic cmpSync;
   logic [BAND_W-1:0] mask;
   logic [BAND_W-1:0] next_band;
   logic wrGo, wrFire, wrStage, wrUpd, wrKnown;
   logic rdGo, rdFire, rdKnown;
   logic [31:0] statusWord;
   logic [31:0] readWord;

   ////////////////////////////////////////////////////////////////////////////////
   // write channel decode; address and data are taken in the same cycle
   assign wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   assign wrFire = s_axi_awvalid && s_axi_awready;
   assign wrStage = wrFire && regHit(s_axi_awaddr, `VCC_OFF_STAGE) && s_axi_wstrb[0];
   assign wrUpd = wrFire && regHit(s_axi_awaddr, `VCC_OFF_UPDATE) && s_axi_wstrb[0]
                  && s_axi_wdata[`VCC_BIT_UPDATE];
   assign wrKnown = regHit(s_axi_awaddr, `VCC_OFF_STAGE) || regHit(s_axi_awaddr, `VCC_OFF_UPDATE);

   // read channel decode; the update register always reads zero
   assign rdGo = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   assign rdFire = s_axi_arvalid && s_axi_arready;
   assign rdKnown = regHit(s_axi_araddr, `VCC_OFF_STAGE) || regHit(s_axi_araddr, `VCC_OFF_UPDATE)
                    || regHit(s_axi_araddr, `VCC_OFF_STATUS) || regHit(s_axi_araddr, `VCC_OFF_BAND);
   assign statusWord = {{`VCC_STATUS_PAD{1'b0}}, calDone, calBusy, activeCfg.div, activeCfg.trig};
   assign readWord = regHit(s_axi_araddr, `VCC_OFF_STAGE) ? {29'h0, stageCfg.div, stageCfg.trig} :
                     regHit(s_axi_araddr, `VCC_OFF_STATUS) ? statusWord :
                     regHit(s_axi_araddr, `VCC_OFF_BAND) ? {{(32-BAND_W){1'b0}}, vcoBand} :
                     32'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // write handshake and response
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'h0;
         s_axi_wready <= 1'h0;
         s_axi_bvalid <= 1'h0;
         s_axi_bresp <= `VCC_RESP_OKAY;
      end else begin
         s_axi_awready <= wrGo;
         s_axi_wready <= wrGo;
         if (wrFire) begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp <= wrKnown ? `VCC_RESP_OKAY : `VCC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'h0;
         end
      end
   end

   // read handshake and data
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid <= 1'h0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `VCC_RESP_OKAY;
      end else begin
         s_axi_arready <= rdGo;
         if (rdFire) begin
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= rdKnown ? `VCC_RESP_OKAY : `VCC_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // staging and active copies; nothing reaches the engine without an update
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stageCfg <= '{div: `VCC_DIV_RST, trig: `VCC_TRIG_RST};
         activeCfg <= '{div: `VCC_DIV_RST, trig: `VCC_TRIG_RST};
         trigPrev <= `VCC_TRIG_RST;
      end else begin
         if (wrStage) begin
            stageCfg.div <= s_axi_wdata[`VCC_DIV_MSB:`VCC_DIV_LSB];
            stageCfg.trig <= s_axi_wdata[`VCC_BIT_TRIG];
         end
         if (wrUpd) begin
            activeCfg <= stageCfg;
         end
         trigPrev <= activeCfg.trig;
      end
   end

   // only a rising active trigger starts a run
   assign startCal = activeCfg.trig && !trigPrev;

   ////////////////////////////////////////////////////////////////////////////////
   // calibration clock from the reference; restarted so run time is exact
   vcc_cal_div u_div (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .restart(startCal),
      .divSel(activeCfg.div),
      .divTick(divTick),
      .calClk(calClk)
   );

   // comparator from the oscillator is asynchronous
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmpMeta <= 1'h0;
         cmpSync <= 1'h0;
      end else begin
         cmpMeta <= vcoCmpIn;
         cmpSync <= cmpMeta;
      end
   end

   // successive approximation: one band bit per calibration clock period
   assign next_band = (cmpSync ? vcoBand : (vcoBand & ~mask)) | (mask >> 1);

   ////////////////////////////////////////////////////////////////////////////////
   // calibration engine; slower calibration clock means a longer run
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= CAL_IDLE;
         vcoBand <= BAND_MID;
         mask <= '0;
         calBusy <= 1'h0;
         calDone <= 1'h0;
      end else if (!activeCfg.trig) begin
         state <= CAL_IDLE;
         vcoBand <= BAND_MID;
         mask <= '0;
         calBusy <= 1'h0;
         calDone <= 1'h0;
      end else if (startCal) begin
         state <= CAL_RUN;
         vcoBand <= BAND_MID;
         mask <= BAND_MID;
         calBusy <= 1'h1;
         calDone <= 1'h0;
      end else begin
         unique case (state)
            CAL_IDLE: begin
               calBusy <= 1'h0;
            end
            CAL_RUN: begin
               if (divTick) begin
                  vcoBand <= next_band;
                  mask <= mask >> 1;
                  if (mask[0]) begin
                     state <= CAL_IDLE;
                     calBusy <= 1'h0;
                     calDone <= 1'h1;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checking helpers: ratio at start, cycles since tick, cycles of a run
   logic [1:0] startDiv;
   logic divSteady;
   logic [5:0] tickGap;
   logic [15:0] calCycles;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         startDiv <= `VCC_DIV_RST;
         divSteady <= 1'h0;
         tickGap <= '0;
         calCycles <= '0;
      end else begin
         startDiv <= startCal ? activeCfg.div : startDiv;
         divSteady <= startCal ? 1'h1 : (divSteady && activeCfg.div == startDiv);
         tickGap <= startCal ? 6'h00 : (divTick ? 6'h01 : tickGap + 6'h01);
         calCycles <= startCal ? 16'h0 : (calBusy ? calCycles + 16'h1 : calCycles);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_calclk_follows;
      divTick |-> $changed(calClk);
   endproperty
   a_calclk_follows: assert property (p_calclk_follows) else $error("calibration clock missed a tick");

   property p_tick_period;
      (divTick && calBusy && divSteady && activeCfg.div == startDiv) |-> tickGap == 6'(vcc_ratio(startDiv));
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("divide ratio does not match code");

   property p_ratio2_first;
      (startCal && activeCfg.div == 2'h0) |-> ##1 !divTick ##1 !divTick ##1 divTick;
   endproperty
   a_ratio2_first: assert property (p_ratio2_first) else $error("ratio 2 first tick misplaced");

   property p_run_length;
      ($rose(calDone) && divSteady) |-> calCycles == 16'(BAND_W * vcc_ratio(startDiv) + 1);
   endproperty
   a_run_length: assert property (p_run_length) else $error("calibration length wrong for ratio");

   property p_start_on_edge;
      startCal |=> calBusy && mask == BAND_MID && !calDone;
   endproperty
   a_start_on_edge: assert property (p_start_on_edge) else $error("rising trigger did not start");

   property p_no_restart;
      (calDone && activeCfg.trig) |=> !calBusy && calDone;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("steady trigger restarted calibration");

   property p_clear_discards;
      !activeCfg.trig |=> !calDone && !calBusy && vcoBand == BAND_MID;
   endproperty
   a_clear_discards: assert property (p_clear_discards) else $error("result kept after trigger clear");

   property p_stage_only;
      wrStage |=> activeCfg == $past(activeCfg);
   endproperty
   a_stage_only: assert property (p_stage_only) else $error("staged write reached active copy");

   property p_update_copies;
      wrUpd |=> activeCfg == $past(stageCfg);
   endproperty
   a_update_copies: assert property (p_update_copies) else $error("update did not copy staging");

   c_fast_start: cover property (startCal && activeCfg.div == 2'h0);
   c_run_done: cover property ($rose(calDone));
   c_abort: cover property (calBusy && !activeCfg.trig);
   c_update: cover property (wrUpd);

endmodule : vcc_top
